/* hdl/tcc_cap_prescale.sv */
/*
 * Capture event prescaler: passes every edge, every 4th or every 16th.
 * Assumes the edge input is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_cap_prescale import tcc_pkg::*; #(
    parameter int unsigned CNT_W = CAP_CNT_W
) (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic clear, // hold counter at zero
    input wire logic edge_ok, // qualified pin edge, one cycle
    input wire logic [1:0] scale, // 0 every, 1 fourth, 2 sixteenth
    output logic fire // capture event, one cycle
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] last;

    always_comb begin
        case (scale)
            2'h1: last = CNT_W'(CAP_DIV_4 - 1);
            2'h2: last = CNT_W'(CAP_DIV_16 - 1);
            default: last = '0;
        endcase
    end

    // >= so a count left over from a larger setting still fires
    assign fire = edge_ok && (cnt_q >= last);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (fire) begin
            cnt_q <= '0;
        end else if (edge_ok) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

/* hdl/tcc_pkg.sv */
/*
 * Shared constants, types and mode decoding for the timebase capture/compare unit.
 * Assumes a single 50 MHz clock and a byte-wide register port.
 */
`default_nettype none

package tcc_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TB_W = 16;

    // clock figures: the instruction clock is the reference divided by four
    localparam int unsigned REF_CLK_HZ = 50_000_000;
    localparam int unsigned INSTR_DIV = 4;
    localparam int unsigned INSTR_CLK_HZ = REF_CLK_HZ / INSTR_DIV;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MATCH_LO = 4'h1;
    localparam logic [ADDR_W-1:0] REG_MATCH_HI = 4'h2;
    localparam logic [ADDR_W-1:0] REG_TB_LO = 4'h3;
    localparam logic [ADDR_W-1:0] REG_TB_HI = 4'h4;
    localparam logic [ADDR_W-1:0] REG_TB_CTRL = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;

    // values after reset
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] TB_CTRL_RST = 8'h00;
    localparam logic [TB_W-1:0] MATCH_RST = 16'h0000;
    localparam logic [TB_W-1:0] TB_RST = 16'h0000;
    localparam logic [TB_W-1:0] TB_MAX = 16'hFFFF;

    // field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned TBC_RUN_BIT = 0;
    localparam int unsigned TBC_EXT_BIT = 1;
    localparam int unsigned ST_EVENT_BIT = 0;
    localparam int unsigned ST_OVF_BIT = 1;
    localparam int unsigned ST_PEND_BIT = 2;
    localparam int unsigned ST_OE_BIT = 3;
    localparam int unsigned ST_OUT_BIT = 4;

    // capture prescale counts
    localparam int unsigned CAP_CNT_W = 4;
    localparam int unsigned CAP_DIV_4 = 4;
    localparam int unsigned CAP_DIV_16 = 16;

    // synchroniser index of each pin
    localparam int unsigned SYNC_N = 2;
    localparam int unsigned SYNC_CAP = 0;
    localparam int unsigned SYNC_EXT = 1;

    // mode select field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWINT = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

    typedef enum logic [2:0] {
        ACT_NONE,
        ACT_TOGGLE,
        ACT_SET,
        ACT_CLEAR,
        ACT_FLAG,
        ACT_SPECIAL
    } tcc_act_e;

    typedef struct packed {
        logic capture;
        logic cap_fall;
        logic [1:0] cap_scale;
        logic compare;
        logic drive_pin;
        tcc_act_e act;
    } tcc_mode_s;

    function automatic tcc_mode_s tcc_decode(input logic [3:0] m);
        tcc_mode_s r;
        r = '{capture: 1'b0, cap_fall: 1'b0, cap_scale: 2'h0, compare: 1'b0,
              drive_pin: 1'b0, act: ACT_NONE};
        case (m)
            MODE_CAP_FALL: begin
                r.capture = 1'b1;
                r.cap_fall = 1'b1;
            end
            MODE_CAP_RISE: r.capture = 1'b1;
            MODE_CAP_RISE4: begin
                r.capture = 1'b1;
                r.cap_scale = 2'h1;
            end
            MODE_CAP_RISE16: begin
                r.capture = 1'b1;
                r.cap_scale = 2'h2;
            end
            MODE_CMP_TOGGLE: begin
                r.compare = 1'b1;
                r.drive_pin = 1'b1;
                r.act = ACT_TOGGLE;
            end
            MODE_CMP_SET: begin
                r.compare = 1'b1;
                r.drive_pin = 1'b1;
                r.act = ACT_SET;
            end
            MODE_CMP_CLEAR: begin
                r.compare = 1'b1;
                r.drive_pin = 1'b1;
                r.act = ACT_CLEAR;
            end
            MODE_CMP_SWINT: begin
                r.compare = 1'b1;
                r.act = ACT_FLAG;
            end
            MODE_CMP_SPECIAL: begin
                r.compare = 1'b1;
                r.act = ACT_SPECIAL;
            end
            default: r.act = ACT_NONE;
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

/* hdl/tcc_top.sv */
/*
 * Capture/compare unit with its 16-bit timebase, register port and pin logic.
 * Assumes a 50 MHz ref_clk that keeps running in sleep, and asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_top import tcc_pkg::*; #(
    parameter int unsigned INSTR_DIV_P = INSTR_DIV
) (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register address
    input wire logic [DATA_W-1:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic cc_pin_in, // capture/compare pin level
    output logic cc_pin_out, // compare output latch
    output logic cc_pin_oe, // high while compare drives the pin
    input wire logic ext_clk_pin, // external timebase clock pin
    input wire logic sleep_mode, // device asleep
    input wire logic adc_enabled, // converter enabled
    output logic adc_start, // conversion start pulse
    output logic event_flag, // capture/compare event flag
    output logic timebase_overflow_flag // timebase wrapped
);

    localparam int unsigned DIV_W = (INSTR_DIV_P > 1) ? $clog2(INSTR_DIV_P) : 1;

    typedef enum logic {
        TRG_IDLE,
        TRG_WAIT
    } tcc_trg_e;

    // registers
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] tb_ctrl_q;
    logic [TB_W-1:0] match_q;
    logic [TB_W-1:0] tb_q;
    logic [DATA_W-1:0] rdata_q;
    logic event_q;
    logic ovf_q;
    logic out_q;
    logic oe_q;
    logic adc_q;
    tcc_trg_e trg_q;
    logic match_prev_q;
    logic [DIV_W-1:0] div_q;

    // pin synchronisers
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic [SYNC_N-1:0] sync3_q;
    logic [SYNC_N-1:0] pin_raw;

    // decoded strobes and events
    tcc_mode_s mode;
    logic wr_ctrl;
    logic wr_mlo;
    logic wr_mhi;
    logic wr_tlo;
    logic wr_thi;
    logic wr_tbc;
    logic wr_stat;
    logic cap_rise;
    logic cap_fall;
    logic ext_rise;
    logic instr_tick;
    logic tb_tick;
    logic tb_clear;
    logic match_now;
    logic cmp_fire;
    logic cap_edge;
    logic cap_fire;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    assign mode = tcc_decode(ctrl_q[CTRL_MODE_LSB +: 4]);

    assign wr_ctrl = reg_wr && hit(reg_addr, REG_CTRL);
    assign wr_mlo = reg_wr && hit(reg_addr, REG_MATCH_LO);
    assign wr_mhi = reg_wr && hit(reg_addr, REG_MATCH_HI);
    assign wr_tlo = reg_wr && hit(reg_addr, REG_TB_LO);
    assign wr_thi = reg_wr && hit(reg_addr, REG_TB_HI);
    assign wr_tbc = reg_wr && hit(reg_addr, REG_TB_CTRL);
    assign wr_stat = reg_wr && hit(reg_addr, REG_STATUS);

    assign pin_raw[SYNC_CAP] = cc_pin_in;
    assign pin_raw[SYNC_EXT] = ext_clk_pin;

    // first stage feeds only the second; edges come from stages two and three
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    assign cap_rise = sync2_q[SYNC_CAP] && !sync3_q[SYNC_CAP];
    assign cap_fall = !sync2_q[SYNC_CAP] && sync3_q[SYNC_CAP];
    assign ext_rise = sync2_q[SYNC_EXT] && !sync3_q[SYNC_EXT];

    // instruction clock enable, a quarter of the reference rate
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else if (div_q == DIV_W'(INSTR_DIV_P - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    assign instr_tick = (div_q == DIV_W'(INSTR_DIV_P - 1));

    // instruction clock stops in sleep, external clock does not
    always_comb begin
        if (!tb_ctrl_q[TBC_RUN_BIT]) begin
            tb_tick = 1'b0;
        end else if (tb_ctrl_q[TBC_EXT_BIT]) begin
            tb_tick = ext_rise;
        end else begin
            tb_tick = instr_tick && !sleep_mode;
        end
    end

    // capture path
    assign cap_edge = mode.capture && (mode.cap_fall ? cap_fall : cap_rise);

    tcc_cap_prescale #(
        .CNT_W(CAP_CNT_W)
    ) u_prescale (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(!mode.capture),
        .edge_ok(cap_edge),
        .scale(mode.cap_scale),
        .fire(cap_fire)
    );

    // compare path: act on the cycle equality begins, not while it persists
    assign match_now = (tb_q == match_q);
    assign cmp_fire = mode.compare && match_now && !match_prev_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            match_prev_q <= 1'b0;
        end else begin
            match_prev_q <= match_now;
        end
    end

    // special trigger waits for the next timebase edge to clear the count
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trg_q <= TRG_IDLE;
        end else begin
            case (trg_q)
                TRG_IDLE: begin
                    if (cmp_fire && mode.act == ACT_SPECIAL) begin
                        trg_q <= TRG_WAIT;
                    end
                end
                TRG_WAIT: begin
                    if (mode.act != ACT_SPECIAL || !match_now) begin
                        trg_q <= TRG_IDLE;
                    end else if (tb_tick) begin
                        trg_q <= TRG_IDLE;
                    end
                end
                default: trg_q <= TRG_IDLE;
            endcase
        end
    end

    assign tb_clear = (trg_q == TRG_WAIT) && mode.act == ACT_SPECIAL && match_now && tb_tick;

    // conversion start leaves on the match itself
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            adc_q <= 1'b0;
        end else begin
            adc_q <= cmp_fire && mode.act == ACT_SPECIAL && adc_enabled;
        end
    end

    // timebase counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tb_q <= TB_RST;
        end else if (wr_tlo) begin
            tb_q[7:0] <= reg_wdata;
        end else if (wr_thi) begin
            tb_q[15:8] <= reg_wdata;
        end else if (tb_clear) begin
            tb_q <= TB_RST;
        end else if (tb_tick) begin
            tb_q <= tb_q + 16'h0001;
        end
    end

    // overflow flag: only a genuine wrap sets it, write 1 clears, set wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovf_q <= 1'b0;
        end else if (tb_tick && !tb_clear && !wr_tlo && !wr_thi && tb_q == TB_MAX) begin
            ovf_q <= 1'b1;
        end else if (wr_stat && reg_wdata[ST_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    // match pair doubles as capture store; a capture beats a software write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            match_q <= MATCH_RST;
        end else if (cap_fire) begin
            match_q <= tb_q;
        end else if (wr_mlo) begin
            match_q[7:0] <= reg_wdata;
        end else if (wr_mhi) begin
            match_q[15:8] <= reg_wdata;
        end
    end

    // event flag: set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            event_q <= 1'b0;
        end else if (cap_fire || cmp_fire) begin
            event_q <= 1'b1;
        end else if (wr_stat && reg_wdata[ST_EVENT_BIT]) begin
            event_q <= 1'b0;
        end
    end

    // compare output latch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= 1'b0;
        end else if (wr_ctrl && reg_wdata == CTRL_RST) begin
            out_q <= 1'b0;
        end else if (cmp_fire) begin
            case (mode.act)
                ACT_TOGGLE: out_q <= !out_q;
                ACT_SET: out_q <= 1'b1;
                ACT_CLEAR: out_q <= 1'b0;
                default: out_q <= out_q;
            endcase
        end
    end

    // pin ownership only in the three pin-driving compare modes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= mode.drive_pin;
        end
    end

    // control registers; a direct prescale change keeps the count
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tb_ctrl_q <= TB_CTRL_RST;
        end else if (wr_tbc) begin
            tb_ctrl_q <= {6'h00, reg_wdata[TBC_EXT_BIT], reg_wdata[TBC_RUN_BIT]};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: rdata_q <= ctrl_q;
                REG_MATCH_LO: rdata_q <= match_q[7:0];
                REG_MATCH_HI: rdata_q <= match_q[15:8];
                REG_TB_LO: rdata_q <= tb_q[7:0];
                REG_TB_HI: rdata_q <= tb_q[15:8];
                REG_TB_CTRL: rdata_q <= tb_ctrl_q;
                REG_STATUS: begin
                    rdata_q <= '0;
                    rdata_q[ST_EVENT_BIT] <= event_q;
                    rdata_q[ST_OVF_BIT] <= ovf_q;
                    rdata_q[ST_PEND_BIT] <= (trg_q == TRG_WAIT);
                    rdata_q[ST_OE_BIT] <= oe_q;
                    rdata_q[ST_OUT_BIT] <= out_q;
                end
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign cc_pin_out = out_q;
    assign cc_pin_oe = oe_q;
    assign adc_start = adc_q;
    assign event_flag = event_q;
    assign timebase_overflow_flag = ovf_q;

endmodule

`default_nettype wire

/* test/tcc_chk.sv */
/* Port assertions for the capture/compare unit.
   Bound into tcc_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tcc_chk import tcc_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic cc_pin_out, // compare latch
    input wire logic cc_pin_oe, // compare drives pin
    input wire logic adc_enabled, // converter on
    input wire logic adc_start, // conversion start
    input wire logic event_flag // event flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic ctl_wr;
    logic flag_clr;
    assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
    assign flag_clr = reg_wr && (reg_addr == REG_STATUS) && reg_wdata[0];

    property p_off_clear;
        ctl_wr && reg_wdata == 8'h00 |-> ##2 (!cc_pin_oe && !cc_pin_out);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("latch kept after off");
    property p_swint_pin;
        ctl_wr && reg_wdata == 8'h0A |-> ##2 !cc_pin_oe;
    endproperty
    a_swint_pin: assert property (p_swint_pin) else $error("flag mode drives pin");
    property p_special_pin;
        ctl_wr && reg_wdata == 8'h0B |-> ##2 !cc_pin_oe;
    endproperty
    a_special_pin: assert property (p_special_pin) else $error("trigger mode drives pin");
    property p_adc_en;
        adc_start |-> $past(adc_enabled);
    endproperty
    a_adc_en: assert property (p_adc_en) else $error("start while converter off");
    property p_adc_once;
        adc_start |=> !adc_start;
    endproperty
    a_adc_once: assert property (p_adc_once) else $error("start held");
    property p_adc_flag;
        adc_start |-> event_flag;
    endproperty
    a_adc_flag: assert property (p_adc_flag) else $error("trigger without flag");
    property p_out_flag;
        $rose(cc_pin_out) |-> event_flag;
    endproperty
    a_out_flag: assert property (p_out_flag) else $error("pin action without flag");
    property p_flag_hold;
        event_flag && !flag_clr |=> event_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
endmodule

bind tcc_top tcc_chk tcc_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .event_flag(event_flag));
`default_nettype wire

/* test/tcc_pin_src.sv */
/* Event source on the capture/compare pin: bursts of 4-cycle pulses, one every 8 cycles.
   Assumes a one-cycle go from the bench; yields the pin to the unit's driver. */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_src (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic go, // start a burst
    input wire logic [4:0] count, // pulses in burst
    input wire logic dut_out, // compare latch
    input wire logic dut_oe, // compare drives pin
    output logic pin, // resolved pin level
    output logic busy // burst running
);
    logic src_q;
    logic [4:0] left_q;
    logic [2:0] ph_q;
    assign pin = dut_oe ? dut_out : src_q;
    assign busy = left_q != 5'h00;
    // slow pulses so the pin synchroniser never misses an edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            src_q <= 1'b0;
            left_q <= 5'h00;
            ph_q <= 3'h0;
        end else if (go) begin
            left_q <= count;
            ph_q <= 3'h0;
        end else if (busy) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h3) src_q <= 1'b1;
            if (ph_q == 3'h7) begin
                src_q <= 1'b0;
                left_q <= left_q - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* test/timebase_capture_compare_unit_tb.sv */
/* Self-checking bench: compare table, capture, trigger and sleep cases.
   Assumes the pin source model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module timebase_capture_compare_unit_tb import tcc_pkg::*;;
    typedef struct packed {logic [3:0] mode; logic zero; logic out; logic oe;} tcc_row_s;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_mode = 1'b0;
    logic adc_enabled = 1'b0;
    logic go = 1'b0;
    logic [4:0] cnt = 5'h00;
    logic ext_clk = 1'b0;
    logic [7:0] reg_rdata;
    logic cc_pin_out;
    logic cc_pin_oe;
    logic pin;
    logic busy;
    logic adc_start;
    logic event_flag;
    logic ovf;
    int err_total = 0;
    int cmp_count = 0;
    tcc_row_s rows [6] = '{'{4'h8, 1'b1, 1'b1, 1'b1}, '{4'h9, 1'b0, 1'b0, 1'b1},
        '{4'h2, 1'b0, 1'b1, 1'b1}, '{4'h2, 1'b0, 1'b0, 1'b1},
        '{4'hA, 1'b0, 1'b0, 1'b0}, '{4'h8, 1'b0, 1'b1, 1'b1}};
    logic [3:0] cap_mode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
    logic [4:0] cap_need [4] = '{5'h01, 5'h01, 5'h04, 5'h10};

    tcc_top #(.INSTR_DIV_P(INSTR_DIV)) tcc_top_inst (.ref_clk(ref_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cc_pin_in(pin), .cc_pin_out(cc_pin_out),
        .cc_pin_oe(cc_pin_oe), .ext_clk_pin(ext_clk), .sleep_mode(sleep_mode),
        .adc_enabled(adc_enabled), .adc_start(adc_start), .event_flag(event_flag),
        .timebase_overflow_flag(ovf));
    tcc_pin_src tcc_pin_src_inst (.ref_clk(ref_clk), .nrst(nrst), .go(go), .count(cnt),
        .dut_out(cc_pin_out), .dut_oe(cc_pin_oe), .pin(pin), .busy(busy));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        err_total++;
        $display("MISMATCH at %0t: wait ran out", $time);
        conclude();
    endtask

    // each access ends one idle cycle later so strobes never double-assign
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 4'h1, v[15:8]);
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 4'h1, v[15:8]);
    endtask

    task automatic wait_flag();
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge ref_clk);
            if (event_flag === 1'b1) break;
        end
        if (i == 400) timeout();
    endtask

    task automatic pulses(input logic [4:0] n);
        int i;
        cnt <= n;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 200 && busy === 1'b1; i++) @(posedge ref_clk);
        if (busy !== 1'b0) timeout();
        repeat (6) @(posedge ref_clk);
    endtask

    initial begin
        logic [7:0] b;
        logic [15:0] v;
        logic [15:0] w;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], b);
            chk(b, 16'h0000);
        end
        foreach (rows[k]) begin
            wr(REG_TB_CTRL, 8'h00);
            if (rows[k].zero) wr(REG_CTRL, 8'h00);
            wr16(REG_TB_LO, 16'h0000);
            wr16(REG_MATCH_LO, 16'h0010);
            wr(REG_CTRL, {4'h0, rows[k].mode});
            wr(REG_STATUS, 8'h01);
            wr(REG_TB_CTRL, 8'h01);
            wait_flag();
            chk(cc_pin_out, rows[k].out);
            chk(cc_pin_oe, rows[k].oe);
            wr(REG_STATUS, 8'h01);
            repeat (8) @(posedge ref_clk);
            chk(event_flag, 1'b0);
        end
        wr(REG_CTRL, 8'h00);
        chk(cc_pin_out, 1'b0);
        adc_enabled <= 1'b1;
        wr(REG_TB_CTRL, 8'h00);
        wr16(REG_TB_LO, 16'h0000);
        wr(REG_CTRL, 8'h0B);
        wr(REG_STATUS, 8'h03);
        wr(REG_TB_CTRL, 8'h01);
        wait_flag();
        chk(adc_start, 1'b1);
        repeat (6) @(posedge ref_clk);
        rd16(REG_TB_LO, v);
        chk(v < 16'h0004, 1'b1);
        chk(ovf, 1'b0);
        chk(cc_pin_oe, 1'b0);
        adc_enabled <= 1'b0;
        wr(REG_TB_CTRL, 8'h00);
        // flag left from the trigger would hide the next match
        wr(REG_STATUS, 8'h01);
        wr16(REG_TB_LO, 16'h0010);
        wr16(REG_MATCH_LO, 16'h0020);
        chk(event_flag, 1'b1);
        wr(REG_TB_CTRL, 8'h01);
        repeat (12) @(posedge ref_clk);
        rd16(REG_TB_LO, v);
        chk(v > 16'h0010, 1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL, 8'h00);
            wr(REG_TB_CTRL, 8'h00);
            wr16(REG_TB_LO, 16'h1200 + k[15:0]);
            wr(REG_CTRL, {4'h0, cap_mode[k]});
            wr(REG_STATUS, 8'h01);
            if (cap_need[k] > 5'h01) pulses(cap_need[k] - 5'h01);
            chk(event_flag, 1'b0);
            pulses(5'h01);
            chk(event_flag, 1'b1);
            rd16(REG_MATCH_LO, v);
            chk(v, 16'h1200 + k[15:0]);
        end
        pulses(5'h05);
        wr(REG_CTRL, 8'h00);
        wr(REG_CTRL, {4'h0, MODE_CAP_RISE4});
        wr(REG_STATUS, 8'h01);
        pulses(5'h03);
        chk(event_flag, 1'b0);
        pulses(5'h01);
        chk(event_flag, 1'b1);
        wr(REG_CTRL, 8'h00);
        wr(REG_TB_CTRL, 8'h01);
        sleep_mode <= 1'b1;
        rd16(REG_TB_LO, v);
        repeat (20) @(posedge ref_clk);
        rd16(REG_TB_LO, w);
        chk(w, v);
        sleep_mode <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd16(REG_TB_LO, w);
        chk(w > v, 1'b1);
        // external timebase keeps counting and capturing while asleep
        wr(REG_CTRL, 8'h00);
        wr(REG_TB_CTRL, 8'h00);
        wr16(REG_TB_LO, 16'h0000);
        wr(REG_CTRL, {4'h0, MODE_CAP_RISE});
        wr(REG_STATUS, 8'h01);
        wr(REG_TB_CTRL, 8'h03);
        sleep_mode <= 1'b1;
        repeat (3) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        pulses(5'h01);
        chk(event_flag, 1'b1);
        rd16(REG_MATCH_LO, v);
        chk(v, 16'h0003);
        conclude();
    end
endmodule
`default_nettype wire
